//--- rtl/fvd_pkg.sv
package fvd_pkg;

    // serial frame: one address byte, then one data word, msb first
    localparam int FVD_ADDR_BITS = 8;
    localparam int FVD_DATA_BITS = 16;

    // write and read addresses; read = write with bit 7 set
    localparam logic [7:0] FVD_ACT_WADDR = 8'h24;
    localparam logic [7:0] FVD_ACT_RADDR = 8'hA4;
    localparam logic [7:0] FVD_HS_WADDR  = 8'h28;
    localparam logic [7:0] FVD_HS_RADDR  = 8'hA8;
    localparam logic [7:0] FVD_LS_WADDR  = 8'h2C;
    localparam logic [7:0] FVD_LS_RADDR  = 8'hAC;
    localparam int         FVD_RD_BIT    = 7;

    // field positions in the drain monitor words
    localparam int FVD_FIL_LSB   = 12;
    localparam int FVD_THR_U_LSB = 8;
    localparam int FVD_THR_V_LSB = 4;
    localparam int FVD_THR_W_LSB = 0;

    // field positions in the fault action word
    localparam int FVD_ACT_HS_LSB = 4;
    localparam int FVD_ACT_LS_LSB = 0;

    // values after reset and highest defined codes
    localparam logic [1:0] FVD_FIL_RST = 2'h0;
    localparam logic [3:0] FVD_THR_RST = 4'h4;
    localparam logic [3:0] FVD_THR_MAX = 4'hB;
    localparam logic [3:0] FVD_ACT_RST = 4'h7;
    localparam logic [3:0] FVD_ACT_MAX = 4'h9;

    // deglitch filter times and their cycle counts at the core clock
    localparam int FVD_CLK_PERIOD_PS = 5000;
    localparam int FVD_FIL_TIME_US [4] = '{6, 8, 10, 12};
    localparam int FVD_FIL_CYC [4] = '{
        FVD_FIL_TIME_US[0] * 1000000 / FVD_CLK_PERIOD_PS,
        FVD_FIL_TIME_US[1] * 1000000 / FVD_CLK_PERIOD_PS,
        FVD_FIL_TIME_US[2] * 1000000 / FVD_CLK_PERIOD_PS,
        FVD_FIL_TIME_US[3] * 1000000 / FVD_CLK_PERIOD_PS
    };

endpackage : fvd_pkg

//--- rtl/fvd_det_if.sv
`timescale 1ns/10ps
`default_nettype none

// comparator levels, filter selects and filtered faults
interface fvd_det_if;
    logic [5:0] cmp;
    logic [1:0] hs_fil;
    logic [1:0] ls_fil;
    logic [5:0] fault;

    modport ctrl (output cmp, output hs_fil, output ls_fil, input fault);
    modport filt (input cmp, input hs_fil, input ls_fil, output fault);
endinterface : fvd_det_if

`default_nettype wire

//--- rtl/fvd_sync.sv
`timescale 1ns/10ps
`default_nettype none

module fvd_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    logic [W-1:0] nxt_out;

    generate
        if (W < 1) begin : g_bad_width
            $error("fvd_sync: width must be at least one");
        end
    endgenerate

    // a bit moves only when stages two and three agree
    assign nxt_out  = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & out_ff);
    assign sync_out = out_ff;

    // s1 feeds s2 only; metastability settles there
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_ff  <= RST_VAL;
            s2_ff  <= RST_VAL;
            s3_ff  <= RST_VAL;
            out_ff <= RST_VAL;
        end else begin
            s1_ff  <= async_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= nxt_out;
        end
    end
endmodule : fvd_sync

`default_nettype wire

//--- rtl/fvd_deglitch.sv
`timescale 1ns/10ps
`default_nettype none

module fvd_deglitch #(
    parameter int CNT_W = 12
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    fvd_det_if.filt   det
);
    generate
        if ((2 ** CNT_W) <= fvd_pkg::FVD_FIL_CYC[3]) begin : g_bad_cnt
            $error("fvd_deglitch: counter too narrow for longest filter");
        end
    endgenerate

    // cycle count for a filter code
    function automatic logic [CNT_W-1:0] fil_cycles(input logic [1:0] code);
        logic [CNT_W-1:0] cyc;
        cyc = CNT_W'(fvd_pkg::FVD_FIL_CYC[code]);
        return cyc;
    endfunction : fil_cycles

    // channels 0..2 are high side u/v/w, 3..5 low side u/v/w
    genvar ch;
    generate
        for (ch = 0; ch < 6; ch++) begin : g_ch
            logic [CNT_W-1:0] cnt_ff;
            logic             fault_ff;
            wire  [1:0]       code  = (ch < 3) ? det.hs_fil : det.ls_fil;
            wire  [CNT_W-1:0] lim   = fil_cycles(code);
            wire              reach = (cnt_ff >= lim - CNT_W'(1));

            // any low sample restarts the window; fault only after a full run
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cnt_ff   <= '0;
                    fault_ff <= 1'b0;
                end else if (!det.cmp[ch]) begin
                    cnt_ff   <= '0;
                    fault_ff <= 1'b0;
                end else if (reach) begin
                    fault_ff <= 1'b1;
                end else begin
                    cnt_ff   <= cnt_ff + CNT_W'(1);
                end
            end

            assign det.fault[ch] = fault_ff;
        end
    endgenerate
endmodule : fvd_deglitch

`default_nettype wire

//--- rtl/fvd_cfg_top.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - high-side monitor word written at 0x28, read back at 0xA8.
// - low-side monitor word written at 0x2C, read back at 0xAC.
// - high-side bits 13:12 pick filter 6/8/10/12 us; reset 00.
// - low-side bits 13:12 pick filter 6/8/10/12 us; reset 00.
// - high-side bits 11:8 set u threshold 0.1-1.2 V; reset 0100.
// - high-side bits 7:4 set v threshold 0.1-1.2 V; reset 0100.
// - high-side bits 3:0 set w threshold 0.1-1.2 V; reset 0100.
// - low-side bits 11:8 set u threshold 0.1-1.2 V; reset 0100.
// - low-side bits 7:4 set v threshold 0.1-1.2 V; reset 0100.
// - low-side bits 3:0 set w threshold 0.1-1.2 V; reset 0100.
// - undefined code in a written field leaves that field unchanged.
// - separate high and low side fault action fields select response.

module fvd_cfg_top (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    input  wire logic [5:0]  vds_cmp,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    output logic [1:0]       hs_fil_code,
    output logic [11:0]      hs_thr_code,
    output logic [1:0]       ls_fil_code,
    output logic [11:0]      ls_thr_code,
    output logic [3:0]       high_side_fault_action,
    output logic [3:0]       low_side_fault_action,
    output logic [5:0]       vds_fault
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_DONE,
        ST_SKIP
    } fvd_spi_st_t;

    localparam int SYNC_W = 9;
    // chip select idles high so reset does not fake a frame edge
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h002;

    logic [SYNC_W-1:0] sync_bus;
    fvd_spi_st_t       state_ff;
    fvd_spi_st_t       nxt_state;
    logic [3:0]        bit_cnt_ff;
    logic [3:0]        nxt_bit_cnt;
    logic [15:0]       rx_sh_ff;
    logic [7:0]        addr_ff;
    logic [7:0]        nxt_addr;
    logic [15:0]       data_ff;
    logic [15:0]       nxt_data;
    logic [15:0]       tx_sh_ff;
    logic [15:0]       nxt_tx_sh;
    logic              sclk_prev_ff;
    logic              cs_prev_ff;
    logic              miso_ff;
    logic              miso_oe_ff;
    logic [1:0]        hs_fil_ff;
    logic [1:0]        ls_fil_ff;
    logic [11:0]       hs_thr_ff;
    logic [11:0]       ls_thr_ff;
    logic [3:0]        hs_act_ff;
    logic [3:0]        ls_act_ff;
    logic [15:0]       rd_data;

    // pins cross into the core clock through the three-stage filter
    fvd_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in ({vds_cmp, spi_sclk, spi_cs_n, spi_mosi}),
        .sync_out (sync_bus)
    );

    // decoded pin levels and edges
    wire sclk_s    = sync_bus[2];
    wire cs_n_s    = sync_bus[1];
    wire mosi_s    = sync_bus[0];
    wire sclk_rise = sclk_s & ~sclk_prev_ff;
    wire sclk_fall = ~sclk_s & sclk_prev_ff;
    wire cs_fall   = ~cs_n_s & cs_prev_ff;
    wire cs_rise   = cs_n_s & ~cs_prev_ff;

    // shift register view with the bit being sampled now
    wire [15:0] rx_next = {rx_sh_ff[14:0], mosi_s};
    wire [7:0]  addr_in = rx_next[7:0];

    // read decode on the address as it completes
    wire rd_hs  = (addr_in == fvd_pkg::FVD_HS_RADDR);
    wire rd_ls  = (addr_in == fvd_pkg::FVD_LS_RADDR);
    wire rd_act = (addr_in == fvd_pkg::FVD_ACT_RADDR);

    // read words; top two bits and unused bits always zero
    wire [15:0] hs_word  = {2'b00, hs_fil_ff, hs_thr_ff};
    wire [15:0] ls_word  = {2'b00, ls_fil_ff, ls_thr_ff};
    wire [15:0] act_word = {8'h00, hs_act_ff, ls_act_ff};

    // unmapped reads answer all zeros
    assign rd_data = rd_hs  ? hs_word  :
                     rd_ls  ? ls_word  :
                     rd_act ? act_word : 16'h0000;

    // a write commits only for a frame of exactly 24 clocks
    wire wr_go  = (state_ff == ST_DONE) & cs_rise & ~addr_ff[fvd_pkg::FVD_RD_BIT];
    wire wr_hs  = wr_go & (addr_ff == fvd_pkg::FVD_HS_WADDR);
    wire wr_ls  = wr_go & (addr_ff == fvd_pkg::FVD_LS_WADDR);
    wire wr_act = wr_go & (addr_ff == fvd_pkg::FVD_ACT_WADDR);

    // frame sequencer; chip select rising always ends the frame
    always_comb begin
        nxt_state   = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_addr    = addr_ff;
        nxt_data    = data_ff;
        nxt_tx_sh   = tx_sh_ff;
        case (state_ff)
            ST_IDLE: begin
                if (cs_fall) begin
                    nxt_state   = ST_ADDR;
                    nxt_bit_cnt = 4'h0;
                end
            end
            ST_ADDR: begin
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                end else if (sclk_rise) begin
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == 4'(fvd_pkg::FVD_ADDR_BITS - 1)) begin
                        nxt_addr    = addr_in;
                        nxt_tx_sh   = rd_data;
                        nxt_bit_cnt = 4'h0;
                        nxt_state   = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                end else if (sclk_rise) begin
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == 4'(fvd_pkg::FVD_DATA_BITS - 1)) begin
                        nxt_data  = rx_next;
                        nxt_state = ST_DONE;
                    end
                end
                if (sclk_fall) begin
                    nxt_tx_sh = {tx_sh_ff[14:0], 1'b0};
                end
            end
            ST_DONE: begin
                // a 25th clock makes the frame too long; drop it
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                end else if (sclk_rise) begin
                    nxt_state = ST_SKIP;
                end
            end
            ST_SKIP: begin
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff   <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            addr_ff    <= 8'h00;
            data_ff    <= 16'h0000;
            tx_sh_ff   <= 16'h0000;
        end else begin
            state_ff   <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            addr_ff    <= nxt_addr;
            data_ff    <= nxt_data;
            tx_sh_ff   <= nxt_tx_sh;
        end
    end

    // edge history and receive shifter
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_prev_ff <= 1'b0;
            cs_prev_ff   <= 1'b1;
            rx_sh_ff     <= 16'h0000;
        end else begin
            sclk_prev_ff <= sclk_s;
            cs_prev_ff   <= cs_n_s;
            if (cs_fall) begin
                rx_sh_ff <= 16'h0000;
            end else if (sclk_rise) begin
                rx_sh_ff <= rx_next;
            end
        end
    end

    // read data leaves on falling sclk so the host samples on rising
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            miso_ff    <= 1'b0;
            miso_oe_ff <= 1'b0;
        end else begin
            miso_oe_ff <= ~cs_n_s;
            if (cs_n_s) begin
                miso_ff <= 1'b0;
            end else if (sclk_fall && state_ff == ST_DATA) begin
                miso_ff <= tx_sh_ff[15];
            end
        end
    end

    // filter selects: every two-bit code is defined
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hs_fil_ff <= fvd_pkg::FVD_FIL_RST;
            ls_fil_ff <= fvd_pkg::FVD_FIL_RST;
        end else begin
            if (wr_hs) begin
                hs_fil_ff <= data_ff[fvd_pkg::FVD_FIL_LSB +: 2];
            end
            if (wr_ls) begin
                ls_fil_ff <= data_ff[fvd_pkg::FVD_FIL_LSB +: 2];
            end
        end
    end

    // thresholds per phase; nibble 2 is u, 1 is v, 0 is w
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_thr
            wire [3:0] wv    = data_ff[ph*4 +: 4];
            wire       legal = (wv <= fvd_pkg::FVD_THR_MAX);
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    hs_thr_ff[ph*4 +: 4] <= fvd_pkg::FVD_THR_RST;
                    ls_thr_ff[ph*4 +: 4] <= fvd_pkg::FVD_THR_RST;
                end else begin
                    if (wr_hs && legal) begin
                        hs_thr_ff[ph*4 +: 4] <= wv;
                    end
                    if (wr_ls && legal) begin
                        ls_thr_ff[ph*4 +: 4] <= wv;
                    end
                end
            end
        end
    endgenerate

    // fault action codes above the last defined one are dropped
    wire [3:0] act_hs_in = data_ff[fvd_pkg::FVD_ACT_HS_LSB +: 4];
    wire [3:0] act_ls_in = data_ff[fvd_pkg::FVD_ACT_LS_LSB +: 4];
    wire       act_hs_ok = (act_hs_in <= fvd_pkg::FVD_ACT_MAX);
    wire       act_ls_ok = (act_ls_in <= fvd_pkg::FVD_ACT_MAX);

    // response selects, one per side
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hs_act_ff <= fvd_pkg::FVD_ACT_RST;
            ls_act_ff <= fvd_pkg::FVD_ACT_RST;
        end else begin
            if (wr_act && act_hs_ok) begin
                hs_act_ff <= act_hs_in;
            end
            if (wr_act && act_ls_ok) begin
                ls_act_ff <= act_ls_in;
            end
        end
    end

    // comparator filtering lives in its own module
    fvd_det_if u_det_if ();

    assign u_det_if.cmp    = sync_bus[8:3];
    assign u_det_if.hs_fil = hs_fil_ff;
    assign u_det_if.ls_fil = ls_fil_ff;

    fvd_deglitch #(
        .CNT_W (12)
    ) u_deglitch (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .det      (u_det_if.filt)
    );

    // all outputs come from flops
    assign spi_miso               = miso_ff;
    assign spi_miso_oe            = miso_oe_ff;
    assign hs_fil_code            = hs_fil_ff;
    assign ls_fil_code            = ls_fil_ff;
    assign hs_thr_code            = hs_thr_ff;
    assign ls_thr_code            = ls_thr_ff;
    assign high_side_fault_action = hs_act_ff;
    assign low_side_fault_action  = ls_act_ff;
    assign vds_fault              = u_det_if.fault;
endmodule : fvd_cfg_top

`default_nettype wire

//--- test/fvd_cfg_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// sees only top ports; pins are async, so windows leave room for the sync chain
module fvd_cfg_asserts (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        spi_sclk,
    input wire logic        spi_cs_n,
    input wire logic        spi_mosi,
    input wire logic [5:0]  vds_cmp,
    input wire logic        spi_miso,
    input wire logic        spi_miso_oe,
    input wire logic [1:0]  hs_fil_code,
    input wire logic [11:0] hs_thr_code,
    input wire logic [1:0]  ls_fil_code,
    input wire logic [11:0] ls_thr_code,
    input wire logic [3:0]  high_side_fault_action,
    input wire logic [3:0]  low_side_fault_action,
    input wire logic [5:0]  vds_fault
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic [11:0] hi_cnt_ff  [6];
    logic [11:0] nxt_hi_cnt [6];
    logic [11:0] lim        [6];

    // raw pin high time per channel, saturating so a stuck input cannot wrap
    for (genvar i = 0; i < 6; i++) begin : g_ch
        assign nxt_hi_cnt[i] = !vds_cmp[i] ? 12'h000 :
                               (&hi_cnt_ff[i]) ? hi_cnt_ff[i] : hi_cnt_ff[i] + 12'h001;
        assign lim[i] = 12'h4B0 + 12'h190 * 12'((i < 3) ? hs_fil_code : ls_fil_code);
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) hi_cnt_ff[i] <= 12'h000;
            else hi_cnt_ff[i] <= nxt_hi_cnt[i];
        end
        a_fault_late: assert property ($rose(vds_fault[i]) |-> hi_cnt_ff[i] >= lim[i])
            else $error("fault rose before the filter time");
        a_fault_due: assert property (hi_cnt_ff[i] >= lim[i] + 12'h00C |-> vds_fault[i])
            else $error("fault missing after the filter time");
        a_fault_drop: assert property (!vds_cmp[i] [*8] |-> !vds_fault[i])
            else $error("fault stayed with comparator low");
    end

    a_miso_quiet: assert property (spi_cs_n [*8] |-> !spi_miso_oe && !spi_miso)
        else $error("miso active while deselected");
    a_oe_frame: assert property (!spi_cs_n [*8] |-> spi_miso_oe)
        else $error("miso enable low while selected");
    a_hs_hold: assert property (spi_cs_n [*8] ##1 spi_cs_n |-> $stable({hs_fil_code, hs_thr_code}))
        else $error("high side word changed outside a write");
    a_ls_hold: assert property (spi_cs_n [*8] ##1 spi_cs_n |-> $stable({ls_fil_code, ls_thr_code}))
        else $error("low side word changed outside a write");
    a_hs_thr_range: assert property (hs_thr_code[11:8] <= 4'hB && hs_thr_code[7:4] <= 4'hB && hs_thr_code[3:0] <= 4'hB)
        else $error("high side threshold undefined");
    a_ls_thr_range: assert property (ls_thr_code[11:8] <= 4'hB && ls_thr_code[7:4] <= 4'hB && ls_thr_code[3:0] <= 4'hB)
        else $error("low side threshold undefined");
    a_act_range: assert property (high_side_fault_action <= 4'h9 && low_side_fault_action <= 4'h9)
        else $error("fault action undefined");
endmodule : fvd_cfg_asserts

bind fvd_cfg_top fvd_cfg_asserts u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .vds_cmp(vds_cmp), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .hs_fil_code(hs_fil_code), .hs_thr_code(hs_thr_code), .ls_fil_code(ls_fil_code),
    .ls_thr_code(ls_thr_code), .high_side_fault_action(high_side_fault_action),
    .low_side_fault_action(low_side_fault_action), .vds_fault(vds_fault)
);

`default_nettype wire

//--- test/fvd_spi_host.sv
`timescale 1ns/10ps
`default_nettype none

// spi host, mode 0; sclk rests low between frames
module fvd_spi_host (
    input  wire logic core_clk,
    input  wire logic spi_miso,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi
);
    // half period well above the four-flop pin sampler
    localparam int HALF = 8;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // address byte then word, msb first; nbit other than 24 is a broken frame
    task automatic xfer(input logic [23:0] tx, input int nbit, output logic [15:0] rx);
        rx = 16'h0000;
        // requests always open on a rising edge, even when called mid-cycle
        @(posedge core_clk);
        spi_cs_n <= 1'b0;
        repeat (HALF) @(posedge core_clk);
        for (int i = 0; i < nbit; i++) begin
            spi_mosi <= tx[23 - (i % 24)];
            repeat (HALF) @(posedge core_clk);
            spi_sclk <= 1'b1;
            if (i >= 8) rx = {rx[14:0], spi_miso};
            repeat (HALF) @(posedge core_clk);
            spi_sclk <= 1'b0;
        end
        repeat (HALF) @(posedge core_clk);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi; // released line shows no stale bit
        repeat (HALF) @(posedge core_clk);
    endtask : xfer
endmodule : fvd_spi_host

`default_nettype wire

//--- test/fet_vds_detect_config_tb.sv
`timescale 1ns/10ps
`default_nettype none

module fet_vds_detect_config_tb;
    logic        core_clk;
    logic        sys_rst;
    logic        spi_sclk;
    logic        spi_cs_n;
    logic        spi_mosi;
    logic        spi_miso;
    logic        spi_miso_oe;
    logic [5:0]  vds_cmp;
    logic [1:0]  hs_fil_code;
    logic [11:0] hs_thr_code;
    logic [1:0]  ls_fil_code;
    logic [11:0] ls_thr_code;
    logic [3:0]  high_side_fault_action;
    logic [3:0]  low_side_fault_action;
    logic [5:0]  vds_fault;
    logic [15:0] sh [3];
    logic [7:0]  wa [3];
    logic [15:0] rd;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;

    fvd_cfg_top uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .vds_cmp(vds_cmp), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .hs_fil_code(hs_fil_code), .hs_thr_code(hs_thr_code), .ls_fil_code(ls_fil_code),
        .ls_thr_code(ls_thr_code), .high_side_fault_action(high_side_fault_action),
        .low_side_fault_action(low_side_fault_action), .vds_fault(vds_fault)
    );

    fvd_spi_host u_host (
        .core_clk(core_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi)
    );

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // a hang is cut short well past the expected run length
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_fail++;
            $display("Error timeout after %0d cycles", cyc);
            report_and_stop;
        end
    end

    // expected word: undefined codes keep the old field, top bits read zero
    function automatic logic [15:0] upd(input int r, input logic [15:0] o, input logic [15:0] d);
        logic [15:0] n;
        n = 16'h0000;
        if (r == 2) begin
            n[7:4] = (d[7:4] > 4'h9) ? o[7:4] : d[7:4];
            n[3:0] = (d[3:0] > 4'h9) ? o[3:0] : d[3:0];
        end else begin
            n[13:12] = d[13:12];
            for (int f = 0; f < 3; f++) n[f*4 +: 4] = (d[f*4 +: 4] > 4'hB) ? o[f*4 +: 4] : d[f*4 +: 4];
        end
        return n;
    endfunction : upd

    // pins and read back of all three words
    task automatic check_regs;
        @(negedge core_clk);
        chk("hs_out", 16'({hs_fil_code, hs_thr_code}), sh[0]);
        chk("ls_out", 16'({ls_fil_code, ls_thr_code}), sh[1]);
        chk("act_out", 16'({high_side_fault_action, low_side_fault_action}), sh[2]);
        for (int r = 0; r < 3; r++) begin
            u_host.xfer({wa[r] | 8'h80, 16'h0000}, 24, rd);
            chk("readback", rd, sh[r]);
        end
    endtask : check_regs

    task automatic wr(input int r, input logic [15:0] d);
        u_host.xfer({wa[r], d}, 24, rd);
        sh[r] = upd(r, sh[r], d);
        repeat (4) @(posedge core_clk);
        check_regs;
    endtask : wr

    // held level, short drop that must restart the count, then release
    task automatic filt_test(input int c);
        int lim;
        lim = (6 + 2 * (c % 4)) * 200;
        wr(c / 3, {2'b00, 2'(c % 4), sh[c / 3][11:0]});
        vds_cmp[c] <= 1'b1;
        repeat (lim / 2) @(posedge core_clk);
        vds_cmp[c] <= 1'b0;
        repeat (4) @(posedge core_clk);
        vds_cmp[c] <= 1'b1;
        // fault due lim+4 edges after the pin; check just before it
        repeat (lim + 3) @(negedge core_clk);
        chk("fault_early", 16'(vds_fault), 16'h0000);
        // hold long enough that the checker's fault-due window is reached
        repeat (13) @(negedge core_clk);
        chk("fault_set", 16'(vds_fault), 16'(1 << c));
        @(posedge core_clk);
        vds_cmp[c] <= 1'b0;
        repeat (8) @(negedge core_clk);
        chk("fault_clr", 16'(vds_fault), 16'h0000);
    endtask : filt_test

    initial begin
        sys_rst = 1'b1;
        vds_cmp = 6'h00;
        wa = '{8'h28, 8'h2C, 8'h24};
        sh = '{16'h0444, 16'h0444, 16'h0077};
        void'($urandom(38224));
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        check_regs;
        // boundary codes, top bits set, undefined codes beside defined ones
        wr(0, 16'hFBBB);
        wr(1, 16'hC000);
        wr(0, 16'h3CCC);
        wr(2, 16'h009A);
        wr(2, 16'h00A9);
        for (int k = 0; k < 8; k++) wr(int'($urandom % 3), 16'($urandom));
        // unmapped address and broken frames leave everything alone
        u_host.xfer({8'h30, 16'h1234}, 24, rd);
        u_host.xfer({8'hB0, 16'h0000}, 24, rd);
        chk("unmapped", rd, 16'h0000);
        u_host.xfer({8'h28, 16'h0123}, 23, rd);
        u_host.xfer({8'h2C, 16'h0123}, 25, rd);
        check_regs;
        for (int c = 0; c < 6; c++) filt_test(c);
        report_and_stop;
    end
endmodule : fet_vds_detect_config_tb

`default_nettype wire
